// [hw/sync_serial_port_pkg.sv]
// constants, register map and types shared by the serial port files
package sync_serial_port_pkg;
  // data path shape
  localparam int DATA_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_AW = 3;
  localparam int ADDR_W = 4;
  // register indices on the plain register port
  localparam logic [ADDR_W-1:0] CTRL0_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] CTRL1_ADDR = 4'h1;
  localparam logic [ADDR_W-1:0] DATA_ADDR = 4'h2;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h3;
  localparam logic [ADDR_W-1:0] PRESCALE_ADDR = 4'h4;
  localparam logic [ADDR_W-1:0] IMASK_ADDR = 4'h5;
  localparam logic [ADDR_W-1:0] RIS_ADDR = 4'h6;
  localparam logic [ADDR_W-1:0] MIS_ADDR = 4'h7;
  localparam logic [ADDR_W-1:0] ICLR_ADDR = 4'h8;
  localparam logic [ADDR_W-1:0] DMACTL_ADDR = 4'h9;
  // control zero fields: frame size minus one, format, rate field
  localparam int FSIZE_LSB = 0;
  localparam int FMT_BIT = 4;
  localparam int SCR_LSB = 8;
  localparam logic [3:0] FSIZE_MIN = 4'h3;
  localparam logic [3:0] FSIZE_RESET = 4'h7;
  // control one fields
  localparam int EN_BIT = 0;
  localparam int SLAVE_BIT = 1;
  // prescaler: even divisor, smallest legal value at reset
  localparam logic [7:0] PRESCALE_RESET = 8'h02;
  // interrupt bit positions
  localparam int IRQ_W = 5;
  localparam int TXS_BIT = 0;
  localparam int RXS_BIT = 1;
  localparam int RTO_BIT = 2;
  localparam int ROR_BIT = 3;
  localparam int EOT_BIT = 4;
  // dma enable bits
  localparam int DMA_RX_BIT = 0;
  localparam int DMA_TX_BIT = 1;
  // time-out: 32 serial periods counted as 64 half periods
  localparam int TIMEOUT_PERIODS = 32;
  localparam logic [6:0] TIMEOUT_HALVES = 7'(2 * TIMEOUT_PERIODS);
  // engine states
  typedef enum logic [0:0] {ST_IDLE, ST_SHIFT} state_t;
endpackage

// [hw/sync_word_fifo.sv]
// word fifo with zero-cleared storage and stale read when empty
`timescale 1ns/1ps
module sync_word_fifo
  import sync_serial_port_pkg::*;
#(
  parameter int W = DATA_W,
  parameter int AW = FIFO_AW
)(
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // fill side
  input wire logic push,
  input wire logic [W-1:0] wdata,
  // drain side
  input wire logic pop,
  output logic [W-1:0] rdata,
  output logic [AW:0] count
);
  localparam int DEPTH = 1 << AW;
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [W-1:0] mem_q [DEPTH]; // word storage
  logic [AW-1:0] wptr_q; // next slot to write
  logic [AW-1:0] rptr_q; // oldest word
  logic do_push; // accepted write
  logic do_pop; // accepted read

  assign do_push = push && (count != FULL_CNT);
  assign do_pop = pop && (count != '0);
  // when empty, rptr equals wptr: the slot holds the word written
  // eight writes ago, or zero if fewer than eight writes since reset
  assign rdata = mem_q[rptr_q];

  // storage, cleared at reset so an early underrun reads zero
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= '0;
    end
    else if (do_push)
      mem_q[wptr_q] <= wdata;
  end

  // pointers and fill level
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      wptr_q <= '0;
      rptr_q <= '0;
      count <= '0;
    end
    else
    begin
      if (do_push)
        wptr_q <= wptr_q + 1'b1;
      if (do_pop)
        rptr_q <= rptr_q + 1'b1;
      if (do_push && !do_pop)
        count <= count + 1'b1;
      else if (do_pop && !do_push)
        count <= count - 1'b1;
    end
  end
endmodule

// [hw/sync_serial_port.sv]
// synchronous serial port, master or slave, with word fifos
// What this block does
// - runs master or slave, two frame formats
// - separate eight-word buffers each direction
// - dma requests enabled by dma control bits
// - even prescale divisor from 2 to 254
// - further divide by rate field plus one
// - transmit buffer filled by data port writes
// - slave underrun resends eighth recent word
// - fewer than eight writes means send zero
// - transmit half-empty level can raise request
// - receive pin registered, data reads pop
// - transmit service when half full or less
// - receive interrupt when half full or more, dma when not empty
// - all sources ored into one request
// - mask bit one lets a source through
// - raw and masked status both readable
// - time-out counts 32 periods from non-empty
// - emptying the buffer cancels the time-out
// - writing one clears the time-out flag
// - end of transmission flag when all shifted
// - frames 4 to 16 bits, msb first
// - serial clock idle unless transferring
`timescale 1ns/1ps
module sync_serial_port
  import sync_serial_port_pkg::*;
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic NRST,
  // register port
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [DATA_W-1:0] RDATA,
  // serial clock pin
  input wire logic SCLK_I,
  output logic SCLK_O,
  output logic SCLK_OE,
  // frame / select pin
  input wire logic FSS_I,
  output logic FSS_O,
  output logic FSS_OE,
  // data pins
  output logic TX_O,
  output logic TX_OE,
  input wire logic RX_I,
  // interrupt and dma requests
  output logic INTR,
  output logic TX_DMA_REQ,
  output logic RX_DMA_REQ
);
  localparam logic [FIFO_AW:0] HALF_LVL = (FIFO_AW+1)'(FIFO_DEPTH / 2);
  localparam logic [FIFO_AW:0] FULL_LVL = (FIFO_AW+1)'(FIFO_DEPTH);

  // clamp the frame size field to the shortest legal frame
  function automatic logic [3:0] frame_top(input logic [3:0] f);
    frame_top = (f < FSIZE_MIN) ? FSIZE_MIN : f;
  endfunction

  // keep only the bits that belong to the frame
  function automatic logic [DATA_W-1:0] frame_mask(input logic [DATA_W-1:0] w,
                                                   input logic [3:0] top);
    logic [DATA_W-1:0] r;
    r = '0;
    for (int i = 0; i < DATA_W; i++)
      if (4'(i) <= top)
        r[i] = w[i];
    frame_mask = r;
  endfunction

  // configuration registers
  logic [3:0] fsize_q; // frame length minus one
  logic fmt_q; // 0 spi style select, 1 sync pulse format
  logic [7:0] scr_q; // serial clock rate field
  logic en_q; // port enable
  logic slave_q; // 1 slave, 0 master
  logic [7:0] prescale_q; // even prescale divisor
  logic [IRQ_W-1:0] imask_q; // interrupt mask, one enables
  logic [1:0] dmactl_q; // dma enables
  // sticky event flags
  logic rto_q; // receive time-out
  logic ror_q; // receive overrun
  logic eot_q; // end of transmission
  // pin synchronisers, first stage read only by second
  logic sclk_m_q, sclk_s_q, sclk_p_q;
  logic fss_m_q, fss_s_q, fss_p_q;
  logic rx_m_q, rx_s_q;
  // rate generator
  logic [6:0] pre_cnt_q; // prescale half counter
  logic [7:0] scr_cnt_q; // rate field counter
  logic pre_tick; // one prescale step
  logic half_tick; // half a serial period
  // engine
  state_t st_q; // idle or shifting
  logic [DATA_W-1:0] tx_word_q; // word being sent
  logic [DATA_W-1:0] rx_sh_q; // receive shifter
  logic [3:0] bit_q; // index of bit on the line
  logic sclk_q; // master clock level
  logic start_ev; // a frame begins
  logic rise_ev; // serial clock rising
  logic fall_ev; // serial clock falling
  logic end_ev; // a frame completes
  logic [DATA_W-1:0] rx_word; // completed receive word
  // fifos
  logic [FIFO_AW:0] tx_cnt, rx_cnt;
  logic [DATA_W-1:0] tx_rdata, rx_rdata;
  logic tx_push, tx_pop, rx_push, rx_pop;
  // time-out
  logic [6:0] to_cnt_q; // half periods since non-empty
  logic to_run_q; // counter armed
  logic rx_empty_p_q; // previous empty state
  // status vectors
  logic [IRQ_W-1:0] ris; // raw status
  logic [IRQ_W-1:0] mis; // masked status
  logic is_wr_data, is_rd_data, icr_wr;

  // register port decode
  assign is_wr_data = WR && (ADDR == DATA_ADDR);
  assign is_rd_data = RD && (ADDR == DATA_ADDR);
  assign icr_wr = WR && (ADDR == ICLR_ADDR);
  assign tx_push = is_wr_data;
  assign rx_pop = is_rd_data;

  // transmit buffer
  sync_word_fifo #(.W(DATA_W), .AW(FIFO_AW)) tx_fifo (
    .clock(CLOCK),
    .nrst(NRST),
    .push(tx_push),
    .wdata(WDATA),
    .pop(tx_pop),
    .rdata(tx_rdata),
    .count(tx_cnt)
  );

  // receive buffer
  sync_word_fifo #(.W(DATA_W), .AW(FIFO_AW)) rx_fifo (
    .clock(CLOCK),
    .nrst(NRST),
    .push(rx_push),
    .wdata(rx_word),
    .pop(rx_pop),
    .rdata(rx_rdata),
    .count(rx_cnt)
  );

  // configuration writes
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      fsize_q <= FSIZE_RESET;
      fmt_q <= 1'b0;
      scr_q <= '0;
      en_q <= 1'b0;
      slave_q <= 1'b0;
      prescale_q <= PRESCALE_RESET;
      imask_q <= '0;
      dmactl_q <= '0;
    end
    else if (WR)
    begin
      case (ADDR)
        CTRL0_ADDR:
        begin
          fsize_q <= WDATA[FSIZE_LSB +: 4];
          fmt_q <= WDATA[FMT_BIT];
          scr_q <= WDATA[SCR_LSB +: 8];
        end
        CTRL1_ADDR:
        begin
          en_q <= WDATA[EN_BIT];
          slave_q <= WDATA[SLAVE_BIT];
        end
        // odd divisors drop to even; zero would stall, so it becomes two
        PRESCALE_ADDR:
          prescale_q <= (WDATA[7:1] == '0) ? PRESCALE_RESET
                                           : {WDATA[7:1], 1'b0};
        IMASK_ADDR: imask_q <= WDATA[IRQ_W-1:0];
        DMACTL_ADDR: dmactl_q <= WDATA[1:0];
        default: ; // other offsets have no stored bits
      endcase
    end
  end

  // two-flop synchronisers on every pin input
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      sclk_m_q <= 1'b0;
      sclk_s_q <= 1'b0;
      sclk_p_q <= 1'b0;
      fss_m_q <= 1'b1;
      fss_s_q <= 1'b1;
      fss_p_q <= 1'b1;
      rx_m_q <= 1'b0;
      rx_s_q <= 1'b0;
    end
    else
    begin
      sclk_m_q <= SCLK_I;
      sclk_s_q <= sclk_m_q;
      sclk_p_q <= sclk_s_q; // edge history, reads second stage
      fss_m_q <= FSS_I;
      fss_s_q <= fss_m_q;
      fss_p_q <= fss_s_q;
      rx_m_q <= RX_I;
      rx_s_q <= rx_m_q;
    end
  end

  // rate generator: a half period is prescale/2 times (rate+1) clocks,
  // so a full bit is prescale times (rate+1); runs freely for time-out
  assign pre_tick = (pre_cnt_q == prescale_q[7:1] - 7'h01);
  assign half_tick = pre_tick && (scr_cnt_q == scr_q);
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      pre_cnt_q <= '0;
      scr_cnt_q <= '0;
    end
    else
    begin
      pre_cnt_q <= pre_tick ? '0 : pre_cnt_q + 7'h01;
      if (half_tick)
        scr_cnt_q <= '0;
      else if (pre_tick)
        scr_cnt_q <= scr_cnt_q + 8'h01;
    end
  end

  // edge events: master from its own divider, slave from the pin;
  // slave relies on the far clock being far slower than ours
  assign rise_ev = slave_q ? (sclk_s_q && !sclk_p_q)
                           : (half_tick && !sclk_q);
  assign fall_ev = slave_q ? (!sclk_s_q && sclk_p_q)
                           : (half_tick && sclk_q);
  // frame start: master when data waits, slave on select edge
  always_comb
  begin
    start_ev = 1'b0;
    if (st_q == ST_IDLE && en_q)
    begin
      if (!slave_q)
        start_ev = half_tick && (tx_cnt != '0);
      else if (fmt_q)
        start_ev = fss_s_q && !fss_p_q;
      else
        start_ev = !fss_s_q && fss_p_q;
    end
  end
  // slave ends on last rising edge, master on the falling edge after it
  assign end_ev = (st_q == ST_SHIFT) && (bit_q == '0)
                  && (slave_q ? rise_ev : fall_ev);
  assign tx_pop = start_ev && (tx_cnt != '0);
  assign rx_word = frame_mask(slave_q ? {rx_sh_q[DATA_W-2:0], rx_s_q} : rx_sh_q,
                              frame_top(fsize_q));
  assign rx_push = end_ev && (rx_cnt != FULL_LVL);

  // frame engine and line outputs
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      st_q <= ST_IDLE;
      tx_word_q <= '0;
      rx_sh_q <= '0;
      bit_q <= '0;
      sclk_q <= 1'b0;
      TX_O <= 1'b0;
      FSS_O <= 1'b1;
    end
    else if (!en_q)
    begin
      // disabling drops any frame in flight
      st_q <= ST_IDLE;
      sclk_q <= 1'b0;
      FSS_O <= !fmt_q;
    end
    else
    begin
      case (st_q)
        ST_IDLE:
        begin
          sclk_q <= 1'b0;
          FSS_O <= !fmt_q;
          if (start_ev)
          begin
            // empty slave buffer hands back its stale slot
            tx_word_q <= tx_rdata;
            bit_q <= frame_top(fsize_q);
            TX_O <= tx_rdata[frame_top(fsize_q)];
            FSS_O <= fmt_q; // select low, or sync pulse high
            st_q <= ST_SHIFT;
          end
        end
        ST_SHIFT:
        begin
          if (rise_ev)
          begin
            if (!slave_q)
              sclk_q <= 1'b1;
            rx_sh_q <= {rx_sh_q[DATA_W-2:0], rx_s_q};
            if (fmt_q)
              FSS_O <= 1'b0; // sync pulse lasts the first half bit
          end
          if (end_ev)
          begin
            sclk_q <= 1'b0;
            FSS_O <= !fmt_q;
            st_q <= ST_IDLE;
          end
          else if (fall_ev)
          begin
            if (!slave_q)
              sclk_q <= 1'b0;
            bit_q <= bit_q - 4'h1;
            TX_O <= tx_word_q[bit_q - 4'h1];
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // pin enables: master drives clock and select, slave drives data
  // only inside its own frame
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      SCLK_OE <= 1'b0;
      FSS_OE <= 1'b0;
      TX_OE <= 1'b0;
      SCLK_O <= 1'b0;
    end
    else
    begin
      SCLK_OE <= en_q && !slave_q;
      FSS_OE <= en_q && !slave_q;
      TX_OE <= en_q && (!slave_q || st_q == ST_SHIFT);
      SCLK_O <= sclk_q;
    end
  end

  // receive time-out: armed on empty to non-empty, counts half periods
  // even while the line clock is still
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      to_cnt_q <= '0;
      to_run_q <= 1'b0;
      rx_empty_p_q <= 1'b1;
    end
    else
    begin
      rx_empty_p_q <= (rx_cnt == '0);
      if (rx_cnt == '0)
      begin
        to_run_q <= 1'b0;
        to_cnt_q <= '0;
      end
      else if (rx_empty_p_q)
      begin
        to_run_q <= 1'b1;
        to_cnt_q <= '0;
      end
      else if (to_run_q && half_tick)
      begin
        to_cnt_q <= to_cnt_q + 7'h01;
        if (to_cnt_q == TIMEOUT_HALVES - 7'h01)
          to_run_q <= 1'b0;
      end
    end
  end

  // sticky flags: a new event wins over a clear in the same cycle
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      rto_q <= 1'b0;
      ror_q <= 1'b0;
      eot_q <= 1'b0;
    end
    else
    begin
      if (to_run_q && half_tick && rx_cnt != '0
          && to_cnt_q == TIMEOUT_HALVES - 7'h01)
        rto_q <= 1'b1;
      else if (icr_wr && WDATA[RTO_BIT])
        rto_q <= 1'b0;
      if (end_ev && rx_cnt == FULL_LVL)
        ror_q <= 1'b1;
      else if (icr_wr && WDATA[ROR_BIT])
        ror_q <= 1'b0;
      if (end_ev && tx_cnt == '0)
        eot_q <= 1'b1;
      else if (icr_wr && WDATA[EOT_BIT])
        eot_q <= 1'b0;
    end
  end

  // raw and masked status
  always_comb
  begin
    ris = '0;
    ris[TXS_BIT] = (tx_cnt <= HALF_LVL);
    ris[RXS_BIT] = (rx_cnt >= HALF_LVL);
    ris[RTO_BIT] = rto_q;
    ris[ROR_BIT] = ror_q;
    ris[EOT_BIT] = eot_q;
    mis = ris & imask_q;
  end

  // interrupt and dma request outputs
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      INTR <= 1'b0;
      TX_DMA_REQ <= 1'b0;
      RX_DMA_REQ <= 1'b0;
    end
    else
    begin
      INTR <= |mis;
      TX_DMA_REQ <= dmactl_q[DMA_TX_BIT] && ris[TXS_BIT];
      RX_DMA_REQ <= dmactl_q[DMA_RX_BIT] && (rx_cnt != '0);
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
      RDATA <= '0;
    else if (!RD)
      RDATA <= '0;
    else
    begin
      case (ADDR)
        CTRL0_ADDR: RDATA <= {scr_q, 3'h0, fmt_q, fsize_q};
        CTRL1_ADDR: RDATA <= {14'h0000, slave_q, en_q};
        // an empty receive buffer reads zero and pops nothing
        DATA_ADDR: RDATA <= (rx_cnt != '0) ? rx_rdata : '0;
        STATUS_ADDR:
          RDATA <= {3'h0, rx_cnt, tx_cnt, (st_q == ST_SHIFT),
                    (rx_cnt == FULL_LVL), (rx_cnt != '0),
                    (tx_cnt != FULL_LVL), (tx_cnt == '0)};
        PRESCALE_ADDR: RDATA <= {8'h00, prescale_q};
        IMASK_ADDR: RDATA <= {11'h000, imask_q};
        RIS_ADDR: RDATA <= {11'h000, ris};
        MIS_ADDR: RDATA <= {11'h000, mis};
        DMACTL_ADDR: RDATA <= {14'h0000, dmactl_q};
        default: RDATA <= '0; // unmapped and clear register read zero
      endcase
    end
  end
endmodule

// [tb/sync_serial_port_chk.sv]
// assertion checker for the serial port register port and pins
`timescale 1ns/1ps
module sync_serial_port_chk
  import sync_serial_port_pkg::*;
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic NRST,
  // register port
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic RD,
  input wire logic [DATA_W-1:0] RDATA,
  // serial pins
  input wire logic SCLK_O,
  input wire logic SCLK_OE,
  input wire logic FSS_O,
  input wire logic FSS_OE,
  input wire logic TX_OE
);
  logic [4:0] rise_q; // clock rises since the select line last moved
  logic fss_q; // select line one cycle ago
  logic sclk_q; // serial clock one cycle ago
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!NRST);
  // count rises per frame; saturate so a runaway frame cannot wrap to legal
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      rise_q <= 5'h00;
      fss_q <= 1'b1;
      sclk_q <= 1'b0;
    end
    else
    begin
      fss_q <= FSS_O;
      sclk_q <= SCLK_O;
      if (FSS_O != fss_q)
        rise_q <= 5'h00; // frame boundary
      else if (SCLK_O && !sclk_q && rise_q != 5'h1F)
        rise_q <= rise_q + 5'h01;
    end
  end
  // a register read request at one index
  sequence s_read(logic [ADDR_W-1:0] a);
    RD && ADDR == a;
  endsequence
  // a cycle with no read request
  sequence s_no_read;
    !RD;
  endsequence
  AST_RDATA_IDLE: assert property (s_no_read |=> RDATA == 16'h0000)
    else $error("read data not zero outside a read answer");
  AST_CLEAR_READS_ZERO: assert property (s_read(ICLR_ADDR) |=> RDATA == 16'h0000)
    else $error("clear register did not read zero");
  AST_TX_EMPTY_COUNT: assert property (s_read(STATUS_ADDR) |=> RDATA[0] == (RDATA[8:5] == 4'h0))
    else $error("tx empty flag disagrees with tx count");
  AST_TX_FULL_COUNT: assert property (s_read(STATUS_ADDR) |=> RDATA[1] == (RDATA[8:5] != 4'h8))
    else $error("tx not-full flag disagrees with tx count");
  AST_RX_COUNT: assert property (s_read(STATUS_ADDR) |=>
    RDATA[3] == (RDATA[12:9] == 4'h8) && RDATA[2] == (RDATA[12:9] != 4'h0))
    else $error("rx flags disagree with rx count");
  AST_OE_PAIR: assert property (FSS_OE == SCLK_OE)
    else $error("select and clock enables differ");
  AST_MASTER_TXOE: assert property (SCLK_OE |-> TX_OE)
    else $error("master not driving data pin");
  AST_SCLK_IDLE: assert property (!SCLK_OE && !$past(SCLK_OE) |-> !SCLK_O)
    else $error("serial clock active while not master");
  AST_FRAME_MAX: assert property (rise_q <= 5'h10)
    else $error("more than sixteen clock rises in a frame");
  // a status register read is seen at least once
  cover property (s_read(STATUS_ADDR));
endmodule

// [tb/serial_peer_model.sv]
// behavioural serial peripheral on the far side of the master port
`timescale 1ns/1ps
module serial_peer_model
  import sync_serial_port_pkg::*;
#(
  parameter logic [DATA_W-1:0] REPLY_BASE = 16'hC35A
)(
  // pins seen from the peripheral
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic mosi,
  output logic miso,
  // what the last frame brought
  output logic [DATA_W-1:0] got,
  output logic [4:0] nbits
);
  logic [DATA_W-1:0] out_q; // reply being shifted out
  logic [7:0] frames; // frames seen so far
  initial
  begin
    got = 16'h0000;
    nbits = 5'h00;
    frames = 8'h00;
    out_q = 16'h0000;
    miso = 1'b1;
  end
  // select falls: load the next reply, msb on the line at once
  always @(negedge sel_n)
  begin
    out_q = REPLY_BASE + 16'(frames);
    nbits = 5'h00;
    got = 16'h0000;
    miso = out_q[15];
  end
  // capture on the rise, msb first
  always @(posedge sclk)
    if (!sel_n)
    begin
      got = {got[14:0], mosi};
      nbits = nbits + 5'h01;
    end
  // change data on the fall, never near the rise
  always @(negedge sclk)
    if (!sel_n)
    begin
      out_q = out_q << 1;
      miso = out_q[15];
    end
  // released line shows the inverse so a stale bit cannot pass
  always @(posedge sel_n)
  begin
    if (nbits != 5'h00)
      frames = frames + 8'h01;
    miso = ~miso;
  end
endmodule

// [tb/sync_serial_port_bench.sv]
// register level testbench for the serial port in master and slave mode
`timescale 1ns/1ps
module sync_serial_port_bench;
  import sync_serial_port_pkg::*;
  localparam logic [15:0] BASE = 16'hC35A; // peer reply seed
  logic clock, nrst, wr, rd, sclk_o, sclk_oe, fss_o, fss_oe, tx_o, tx_oe, rx_i;
  logic intr, tx_dma, rx_dma;
  logic sclk_i, fss_i; // slave side pins driven by the bench
  logic [ADDR_W-1:0] addr;
  logic [15:0] wdata, rdata, got, v;
  logic [4:0] nbits;
  int n_errors, compares, n;
  // device under test, slave inputs driven by the bench
  sync_serial_port u_sync_serial_port (.CLOCK(clock), .NRST(nrst), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .SCLK_I(sclk_i), .SCLK_O(sclk_o),
    .SCLK_OE(sclk_oe), .FSS_I(fss_i), .FSS_O(fss_o), .FSS_OE(fss_oe), .TX_O(tx_o),
    .TX_OE(tx_oe), .RX_I(rx_i), .INTR(intr), .TX_DMA_REQ(tx_dma), .RX_DMA_REQ(rx_dma));
  // far side peripheral
  serial_peer_model #(.REPLY_BASE(BASE)) u_serial_peer_model (.sclk(sclk_o),
    .sel_n(fss_o), .mosi(tx_o), .miso(rx_i), .got(got), .nbits(nbits));
  // transmit word table
  function automatic logic [15:0] tw(input int k);
    return 16'h3C00 + 16'(k * 16'h0111);
  endfunction
  // verdict and end of run
  task automatic stop_test;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // compare seen against expected
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e)
    begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  // one write cycle
  task automatic wrr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  // one read cycle; data stands only in the cycle after the strobe
  task automatic rdr(input logic [ADDR_W-1:0] a, output logic [15:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // read and compare
  task automatic rc(input logic [ADDR_W-1:0] a, input logic [15:0] e);
    logic [15:0] d;
    rdr(a, d);
    chk(d, e);
  endtask
  // one slave frame clocked at one twelfth of the system clock, msb first
  task automatic sframe(output logic [15:0] d);
    d = 16'h0000;
    repeat (3) @(posedge clock);
    fss_i <= 1'b0;
    for (int b = 0; b < 8; b++)
    begin
      repeat (6) @(posedge clock);
      sclk_i <= 1'b1;
      d = {d[14:0], tx_o};
      repeat (6) @(posedge clock);
      sclk_i <= 1'b0;
    end
    repeat (6) @(posedge clock);
    fss_i <= 1'b1;
  endtask
  // poll until not busy and tx empty, bounded
  task automatic wait_idle;
    logic [15:0] d;
    int i;
    for (i = 0; i < 1000; i++)
    begin
      rdr(STATUS_ADDR, d);
      if (d[4] === 1'b0 && d[0] === 1'b1)
        return;
    end
    n_errors++;
    stop_test();
  endtask
  // one full serial clock period in system cycles
  task automatic period;
    n = 0;
    while (sclk_o !== 1'b1 && n < 200) begin @(negedge clock); n++; end
    n = 0;
    while (sclk_o === 1'b1 && n < 200) begin @(negedge clock); n++; end
    while (sclk_o !== 1'b1 && n < 200) begin @(negedge clock); n++; end
  endtask
  // free running system clock
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // hang guard
  initial
  begin
    repeat (100000) @(posedge clock);
    n_errors++;
    stop_test();
  end
  // main sequence
  initial
  begin
    nrst = 1'b0; wr = 1'b0; rd = 1'b0; addr = '0; wdata = '0;
    sclk_i = 1'b0; fss_i = 1'b1;
    n_errors = 0; compares = 0;
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    rc(CTRL0_ADDR, 16'h0007);
    rc(PRESCALE_ADDR, 16'h0002);
    rc(STATUS_ADDR, 16'h0003);
    rc(RIS_ADDR, 16'h0001);
    rc(4'hF, 16'h0000); // unmapped index
    rc(ICLR_ADDR, 16'h0000);
    wrr(PRESCALE_ADDR, 16'h0005);
    rc(PRESCALE_ADDR, 16'h0004);
    for (int k = 0; k < 9; k++) wrr(DATA_ADDR, tw(k));
    rc(STATUS_ADDR, 16'h0100);
    rc(RIS_ADDR, 16'h0000);
    // 16 bit frames, 12.5 MHz bit clock keeps four times margin
    wrr(CTRL0_ADDR, 16'h010F);
    wrr(CTRL1_ADDR, 16'h0001);
    period();
    chk(16'(n), 16'h0008);
    wait_idle();
    rc(STATUS_ADDR, 16'h100F);
    chk(got, tw(7));
    wrr(DATA_ADDR, tw(9));
    wait_idle();
    chk(got, tw(9));
    rc(RIS_ADDR, 16'h001F);
    wrr(IMASK_ADDR, 16'h0008);
    repeat (3) @(posedge clock);
    chk({15'h0000, intr}, 16'h0001);
    rc(MIS_ADDR, 16'h0008);
    wrr(IMASK_ADDR, 16'h0000);
    repeat (3) @(posedge clock);
    chk({15'h0000, intr}, 16'h0000);
    wrr(ICLR_ADDR, 16'h001C);
    rc(RIS_ADDR, 16'h0003);
    wrr(DMACTL_ADDR, 16'h0003);
    repeat (3) @(posedge clock);
    chk({14'h0000, tx_dma, rx_dma}, 16'h0003);
    for (int k = 0; k < 8; k++) rc(DATA_ADDR, BASE + 16'(k));
    rc(DATA_ADDR, 16'h0000);
    repeat (3) @(posedge clock);
    chk({15'h0000, rx_dma}, 16'h0000);
    // shortest frame, then an early read cancels the time-out
    wrr(CTRL0_ADDR, 16'h0103);
    wrr(DATA_ADDR, 16'hFFFA);
    wait_idle();
    chk({11'h000, nbits}, 16'h0004);
    chk(got, 16'h000A);
    v = (BASE + 16'h0009) >> 12;
    rc(DATA_ADDR, v);
    repeat (300) @(posedge clock);
    rc(RIS_ADDR, 16'h0011);
    wrr(DATA_ADDR, 16'hFFF5);
    wait_idle();
    repeat (300) @(posedge clock);
    rc(RIS_ADDR, 16'h0015);
    wrr(ICLR_ADDR, 16'h0004);
    rc(RIS_ADDR, 16'h0011);
    // fresh reset in mid-run, then slave frames clocked by the bench
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    wrr(CTRL1_ADDR, 16'h0003);
    sframe(v);
    chk(v, 16'h0000);
    for (int k = 1; k < 9; k++) wrr(DATA_ADDR, tw(k));
    for (int k = 0; k < 9; k++)
    begin
      sframe(v);
      chk(v, tw(k % 8 + 1) & 16'h00FF);
    end
    stop_test();
  end
endmodule
// checker beside the top module's ports
bind sync_serial_port sync_serial_port_chk u_sync_serial_port_chk (.CLOCK(CLOCK),
  .NRST(NRST), .ADDR(ADDR), .RD(RD), .RDATA(RDATA), .SCLK_O(SCLK_O),
  .SCLK_OE(SCLK_OE), .FSS_O(FSS_O), .FSS_OE(FSS_OE), .TX_OE(TX_OE));
